// >>> include/bpsp_regs.svh
// Register map, field positions and reset values of the buffered port.
// Assumes inclusion by bare name from the design and bench files.
`ifndef BPSP_REGS_SVH
`define BPSP_REGS_SVH

`define BPSP_ADDR_W        4
`define BPSP_A_MODE        4'h0
`define BPSP_A_STAT_LOW    4'h1
`define BPSP_A_STAT_HIGH   4'h2
`define BPSP_A_OUT_BASE    4'h4
`define BPSP_A_IN_BASE     4'h8
`define BPSP_INC_LSB       0
`define BPSP_IRQ_LSB       2
`define BPSP_MODE_RESET    8'h00
`define BPSP_INC_BUFFERED  2'h3
`define BPSP_IRQ_EVERY     2'h1
`define BPSP_IRQ_FOURTH    2'h3
`define BPSP_UFLOW_BIT     6
`define BPSP_ALLEMPTY_BIT  7
`define BPSP_OVFLOW_BIT    6
`define BPSP_ALLFULL_BIT   7
`define BPSP_LAST_BUF      2'h3
`define BPSP_FIRST_BUF     2'h0

`endif

// >>> include/bpsp_pkg.sv
// Types shared by the buffered port and its write FIFO.
// Assumes the register header is compiled alongside.
package bpsp_pkg;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] data;
  } bpsp_strobe_type;

  typedef struct packed {
    logic [1:0] ptr;
    logic [7:0] data;
  } bpsp_word_type;

  typedef enum logic [0:0] {
    BPSP_IDLE   = 1'b0,
    BPSP_ACTIVE = 1'b1
  } bpsp_state_type;

endpackage

// >>> design/bpsp_fifo.sv
// Small FIFO with valid/ready on both sides.
// Assumes one clock, synchronous active-high reset, clock enable.
`timescale 1ns/1ps

module bpsp_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rptr];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else if (clk_en) begin
      if (push) begin
        mem[wptr] <= in_data;
        wptr      <= (wptr == AW'(DEPTH-1)) ? '0 : wptr + 1'b1;
      end
      if (pop)
        rptr <= (rptr == AW'(DEPTH-1)) ? '0 : rptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> design/bpsp_port.sv
// Buffered slave parallel port: four read and four write byte buffers.
// Assumes strobes synchronous to clk_sys, one cycle each.
`timescale 1ns/1ps
`include "bpsp_regs.svh"

module bpsp_port (
  input  wire logic                      clk_sys,
  input  wire logic                      reset,
  input  wire logic                      clk_en,
  input  wire logic [`BPSP_ADDR_W-1:0]   reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [7:0]                reg_rdata,
  input  wire logic                      port_chip_select,
  input  wire logic                      port_read_strobe,
  input  wire logic                      port_write_strobe,
  input  wire logic [7:0]                port_data_in,
  output logic      [7:0]                port_data_out,
  output logic                           port_data_oe,
  output logic                           port_interrupt_flag,
  output logic                           fifo_stall
);

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0]           port_mode_high_reg;
  logic [7:0]           output_buffer [4];
  logic [7:0]           input_buffer [4];
  logic [3:0]           out_buf_empty_bit;
  logic [3:0]           in_buf_full_bit;
  logic                 out_buf_underflow_flag;
  logic                 in_buf_overflow_flag;
  logic [1:0]           rd_ptr;
  logic [1:0]           wr_ptr;
  bpsp_pkg::bpsp_state_type state;

  ////////////////////////////////////////////////////////////////////////
  // Decode

  wire [1:0] increment_mode_field =
    port_mode_high_reg[`BPSP_INC_LSB +: 2];
  wire [1:0] interrupt_mode_field =
    port_mode_high_reg[`BPSP_IRQ_LSB +: 2];
  wire       buffered_on =
    (increment_mode_field == `BPSP_INC_BUFFERED);

  bpsp_pkg::bpsp_strobe_type strobe;
  assign strobe.rd   = port_chip_select && port_read_strobe;
  assign strobe.wr   = port_chip_select && port_write_strobe;
  assign strobe.data = port_data_in;

  wire bus_rd = buffered_on && strobe.rd;
  wire bus_wr = buffered_on && strobe.wr;

  wire       reg_hit_out = reg_addr[3:2] == 2'(`BPSP_A_OUT_BASE >> 2);
  wire       reg_hit_in  = reg_addr[3:2] == 2'(`BPSP_A_IN_BASE >> 2);
  wire [1:0] reg_idx     = reg_addr[1:0];

  wire all_out_empty_flag = &out_buf_empty_bit;
  wire all_in_full_flag   = &in_buf_full_bit;

  wire [7:0] port_status_low_reg  = {all_out_empty_flag,
    out_buf_underflow_flag, 2'h0, out_buf_empty_bit};
  wire [7:0] port_status_high_reg = {all_in_full_flag,
    in_buf_overflow_flag, 2'h0, in_buf_full_bit};

  ////////////////////////////////////////////////////////////////////////
  // Write FIFO between port strobes and input buffers

  bpsp_pkg::bpsp_word_type fifo_in;
  bpsp_pkg::bpsp_word_type fifo_out;
  logic                    fifo_in_ready;
  logic                    fifo_out_valid;

  assign fifo_in.ptr  = wr_ptr;
  assign fifo_in.data = strobe.data;

  bpsp_fifo #(
    .WIDTH ($bits(bpsp_pkg::bpsp_word_type)),
    .DEPTH (4)
  ) bpsp_fifo_inst (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .clk_en    (clk_en),
    .in_valid  (bus_wr),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (1'b1),
    .out_data  (fifo_out)
  );

  wire       drain     = fifo_out_valid;
  wire [1:0] drain_ptr = fifo_out.ptr;
  wire       drain_ovf = drain && in_buf_full_bit[drain_ptr];
  wire       sw_in_rd  = reg_rd && reg_hit_in;

  ////////////////////////////////////////////////////////////////////////
  // Pointers wrap at buffer 3

  wire [1:0] next_rd_ptr = (rd_ptr == `BPSP_LAST_BUF) ?
    `BPSP_FIRST_BUF : rd_ptr + 2'h1;
  wire [1:0] next_wr_ptr = (wr_ptr == `BPSP_LAST_BUF) ?
    `BPSP_FIRST_BUF : wr_ptr + 2'h1;

  wire irq_every  = interrupt_mode_field == `BPSP_IRQ_EVERY;
  wire irq_fourth = interrupt_mode_field == `BPSP_IRQ_FOURTH;
  wire next_irq   = (irq_every && (bus_rd || bus_wr)) ||
    (irq_fourth && ((bus_rd && rd_ptr == `BPSP_LAST_BUF) ||
                    (bus_wr && wr_ptr == `BPSP_LAST_BUF)));

  ////////////////////////////////////////////////////////////////////////
  // Mode state and pointers

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state  <= bpsp_pkg::BPSP_IDLE;
      rd_ptr <= `BPSP_FIRST_BUF;
      wr_ptr <= `BPSP_FIRST_BUF;
    end else if (clk_en) begin
      unique case (state)
        bpsp_pkg::BPSP_IDLE: begin
          if (buffered_on)
            state <= bpsp_pkg::BPSP_ACTIVE;
          if (bus_rd)
            rd_ptr <= next_rd_ptr;
          if (bus_wr && fifo_in_ready)
            wr_ptr <= next_wr_ptr;
        end
        bpsp_pkg::BPSP_ACTIVE: begin
          if (!buffered_on) begin
            state  <= bpsp_pkg::BPSP_IDLE;
            rd_ptr <= `BPSP_FIRST_BUF;
            wr_ptr <= `BPSP_FIRST_BUF;
          end
          if (bus_rd)
            rd_ptr <= next_rd_ptr;
          if (bus_wr && fifo_in_ready)
            wr_ptr <= next_wr_ptr;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read side: drive byte, empty bits, underflow

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      port_data_out <= 8'h00;
      port_data_oe  <= 1'b0;
    end else if (clk_en) begin
      port_data_oe <= bus_rd;
      if (bus_rd)
        port_data_out <= output_buffer[rd_ptr];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      out_buf_empty_bit      <= 4'hF;
      out_buf_underflow_flag <= 1'b0;
      for (int i = 0; i < 4; i++)
        output_buffer[i] <= 8'h00;
    end else if (clk_en) begin
      for (int i = 0; i < 4; i++) begin
        if (reg_wr && reg_hit_out && reg_idx == i[1:0]) begin
          output_buffer[i]     <= reg_wdata;
          out_buf_empty_bit[i] <= 1'b0;
        end
        if (bus_rd && rd_ptr == i[1:0])
          out_buf_empty_bit[i] <= 1'b1;
      end
      if (bus_rd && out_buf_empty_bit[rd_ptr])
        out_buf_underflow_flag <= 1'b1;
      else if (reg_wr && reg_addr == `BPSP_A_STAT_LOW &&
               reg_wdata[`BPSP_UFLOW_BIT])
        out_buf_underflow_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write side: input buffers, full bits, overflow

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      in_buf_full_bit      <= 4'h0;
      in_buf_overflow_flag <= 1'b0;
      for (int i = 0; i < 4; i++)
        input_buffer[i] <= 8'h00;
    end else if (clk_en) begin
      for (int i = 0; i < 4; i++) begin
        if (sw_in_rd && reg_idx == i[1:0])
          in_buf_full_bit[i] <= 1'b0;
        if (drain && drain_ptr == i[1:0]) begin
          in_buf_full_bit[i] <= 1'b1;
          if (!in_buf_full_bit[i])
            input_buffer[i] <= fifo_out.data;
        end
      end
      if (drain_ovf)
        in_buf_overflow_flag <= 1'b1;
      else if (reg_wr && reg_addr == `BPSP_A_STAT_HIGH &&
               reg_wdata[`BPSP_OVFLOW_BIT])
        in_buf_overflow_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt pulse, stall, mode register and read data

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      port_interrupt_flag <= 1'b0;
      fifo_stall          <= 1'b0;
      port_mode_high_reg  <= `BPSP_MODE_RESET;
    end else if (clk_en) begin
      port_interrupt_flag <= next_irq;
      fifo_stall          <= !fifo_in_ready;
      if (reg_wr && reg_addr == `BPSP_A_MODE)
        port_mode_high_reg <= reg_wdata;
    end
  end

  wire [7:0] rd_mux =
    reg_hit_out                    ? output_buffer[reg_idx] :
    reg_hit_in                     ? input_buffer[reg_idx] :
    reg_addr == `BPSP_A_MODE       ? port_mode_high_reg :
    reg_addr == `BPSP_A_STAT_LOW   ? port_status_low_reg :
    reg_addr == `BPSP_A_STAT_HIGH  ? port_status_high_reg : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (clk_en)
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
  end
endmodule

// >>> bench/bpsp_port_assertions.sv
// Port-level checks of the buffered parallel port.
// Assumes binding to bpsp_port; clk_en held high by the bench.
`timescale 1ns/1ps

module bpsp_port_assertions (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       port_chip_select,
  input wire logic       port_read_strobe,
  input wire logic       port_write_strobe,
  input wire logic [7:0] port_data_out,
  input wire logic       port_data_oe,
  input wire logic       port_interrupt_flag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  chk_oe_after_read: assert property (port_data_oe |->
    $past(port_read_strobe && port_chip_select))
    else $error("data enable without read strobe");
  chk_data_on_read: assert property (!$stable(port_data_out) |->
    $past(port_read_strobe && port_chip_select))
    else $error("data out changed without read strobe");
  chk_irq_cause: assert property (port_interrupt_flag |->
    $past((port_read_strobe || port_write_strobe) && port_chip_select))
    else $error("interrupt without strobe");
  chk_rdata_cause: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
    else $error("read data without read strobe");
  chk_wr_no_data: assert property ($past(reg_wr) |-> reg_rdata == 8'h00)
    else $error("read data after register write");
  chk_reset_quiet: assert property ($past(reset) |-> !port_data_oe &&
    !port_interrupt_flag && port_data_out == 8'h00 && reg_rdata == 8'h00)
    else $error("outputs not cleared by reset");
  chk_write_holds: assert property (port_write_strobe &&
    !port_read_strobe |=> $stable(port_data_out))
    else $error("write strobe disturbed data out");
  chk_select_gate: assert property (!port_chip_select |=>
    !port_data_oe ##0 !port_interrupt_flag)
    else $error("response without chip select");
endmodule

bind bpsp_port bpsp_port_assertions bpsp_port_assertions_inst (
  .clk_sys(clk_sys), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .port_chip_select(port_chip_select),
  .port_read_strobe(port_read_strobe),
  .port_write_strobe(port_write_strobe), .port_data_out(port_data_out),
  .port_data_oe(port_data_oe), .port_interrupt_flag(port_interrupt_flag));

// >>> bench/bpsp_master_model.sv
// External master issuing one strobe per cycle in bursts.
// Assumes a rising-edge clock shared with the port.
`timescale 1ns/1ps

module bpsp_master_model (
  input  wire logic       clk_sys,
  output logic            port_chip_select,
  output logic            port_read_strobe,
  output logic            port_write_strobe,
  output logic      [7:0] port_data_in
);
  initial begin
    port_chip_select  = 1'h0;
    port_read_strobe  = 1'h0;
    port_write_strobe = 1'h0;
    port_data_in      = 8'h5A;
  end

  // Idle bus shows inverted data, never the last byte
  task automatic burst(input logic wr, input int n, input logic [7:0] d0);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      port_chip_select  <= 1'h1;
      port_read_strobe  <= !wr;
      port_write_strobe <= wr;
      port_data_in      <= 8'(d0 + i);
    end
    @(posedge clk_sys);
    port_chip_select  <= 1'h0;
    port_read_strobe  <= 1'h0;
    port_write_strobe <= 1'h0;
    port_data_in      <= ~port_data_in;
  endtask
endmodule

// >>> bench/bpsp_port_tb.sv
// Self-checking bench for the buffered parallel port.
// Assumes the master model and the checker compile alongside.
`timescale 1ns/1ps
`include "bpsp_regs.svh"

module bpsp_port_tb;
  logic                    clk_sys = 1'h0;
  logic                    reset = 1'h1;
  logic [`BPSP_ADDR_W-1:0] reg_addr = 4'h0;
  logic [7:0]              reg_wdata = 8'h00;
  logic                    reg_wr = 1'h0;
  logic                    reg_rd = 1'h0;
  logic [7:0]              reg_rdata;
  logic [7:0]              port_data_out;
  logic [7:0]              port_data_in;
  logic                    cs;
  logic                    rds;
  logic                    wrs;
  logic                    oe;
  logic                    irq;
  logic                    stall;
  int                      stall_n = 0;
  int                      err_total = 0;
  int                      compares = 0;
  int                      irq_n = 0;
  logic [7:0]              rd_q[$];

  initial forever #5 clk_sys = ~clk_sys;

  bpsp_port bpsp_port_inst (
    .clk_sys(clk_sys), .reset(reset), .clk_en(1'h1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_chip_select(cs),
    .port_read_strobe(rds), .port_write_strobe(wrs),
    .port_data_in(port_data_in), .port_data_out(port_data_out),
    .port_data_oe(oe), .port_interrupt_flag(irq), .fifo_stall(stall));

  bpsp_master_model bpsp_master_model_inst (
    .clk_sys(clk_sys), .port_chip_select(cs), .port_read_strobe(rds),
    .port_write_strobe(wrs), .port_data_in(port_data_in));

  always @(posedge clk_sys) begin
    if (oe === 1'h1) rd_q.push_back(port_data_out);
    if (irq === 1'h1) irq_n++;
    if (stall === 1'h1) stall_n++;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge clk_sys);
    reg_wr    <= 1'h0;
  endtask

  task automatic reg_read(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge clk_sys);
    reg_rd   <= 1'h0;
    #1 check(reg_rdata, exp);
  endtask

  task automatic settle;
    repeat (2) @(posedge clk_sys);
  endtask

  task automatic wrap_up;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    err_total++;
    wrap_up();
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'h0;
    reg_read(`BPSP_A_STAT_LOW, 8'h8F);
    reg_read(`BPSP_A_STAT_HIGH, 8'h00);
    reg_read(4'hF, 8'h00);
    reg_write(`BPSP_A_MODE, {4'h0, `BPSP_IRQ_EVERY, `BPSP_INC_BUFFERED});
    for (int i = 0; i < 4; i++)
      reg_write(4'(`BPSP_A_OUT_BASE + i), 8'(8'hA0 + i));
    reg_read(`BPSP_A_STAT_LOW, 8'h00);
    bpsp_master_model_inst.burst(1'h0, 5, 8'h00);
    settle();
    check(8'(rd_q.size()), 8'h05);
    for (int i = 0; i < 5; i++) check(rd_q[i], 8'(8'hA0 + i % 4));
    check(8'(irq_n), 8'h05);
    reg_read(`BPSP_A_STAT_LOW, 8'hCF);
    reg_write(`BPSP_A_STAT_LOW, 8'h40);
    reg_read(`BPSP_A_STAT_LOW, 8'h8F);
    bpsp_master_model_inst.burst(1'h1, 5, 8'hB0);
    settle();
    reg_read(`BPSP_A_STAT_HIGH, 8'hCF);
    check(8'(irq_n), 8'h0A);
    check(8'(stall_n), 8'h00);
    for (int i = 0; i < 4; i++)
      reg_read(4'(`BPSP_A_IN_BASE + i), 8'(8'hB0 + i));
    reg_read(`BPSP_A_STAT_HIGH, 8'h40);
    reg_write(`BPSP_A_STAT_HIGH, 8'h40);
    reg_write(`BPSP_A_MODE, 8'h00);
    irq_n = 0;
    bpsp_master_model_inst.burst(1'h1, 1, 8'hEE);
    settle();
    reg_read(`BPSP_A_STAT_HIGH, 8'h00);
    reg_write(`BPSP_A_MODE, {4'h0, `BPSP_IRQ_FOURTH, `BPSP_INC_BUFFERED});
    bpsp_master_model_inst.burst(1'h1, 3, 8'hC0);
    settle();
    check(8'(irq_n), 8'h00);
    bpsp_master_model_inst.burst(1'h1, 1, 8'hC3);
    settle();
    check(8'(irq_n), 8'h01);
    for (int i = 0; i < 4; i++)
      reg_read(4'(`BPSP_A_IN_BASE + i), 8'(8'hC0 + i));
    reg_read(`BPSP_A_STAT_HIGH, 8'h00);
    wrap_up();
  end
endmodule
